// [term_regs_map.svh]
// register offsets, field positions and reset values of the terminal status and configuration bank
`ifndef TERM_REGS_MAP_SVH
`define TERM_REGS_MAP_SVH

// register indices; the byte address is four times the index
`define IDX_SELFTEST     6'h0F
`define IDX_CFG6         6'h18
`define IDX_CFG7         6'h19
`define IDX_FLAG_PORT    6'h1B
`define IDX_IRQ_STATUS   6'h20
`define IDX_IRQ_MASK     6'h21

`define CFG6_RST         16'h0000
`define CFG7_RST         16'h0000
`define GPF_RST          8'h00
`define IRQ_RST          4'h0
`define CFG6_WMASK       16'hFFF7
`define CFG7_WMASK       16'hFC1F

`define FLAG_CLR_HI      15
`define FLAG_CLR_LO      8
`define FLAG_SET_HI      7
`define FLAG_SET_LO      0
`define COND_ONE_BIT     15
`define COND_GPF_HI      7
`define COND_GPF_LO      2
`define COND_ZERO        16'h0000

`define EV_SELFTEST      0
`define EV_BAD_MSG       1
`define EV_NO_RESP       2
`define EV_GOOD_BLOCK    3
`define IRQ_EVENTS       4

`endif

// [term_regs_pkg.sv]
// types shared by the terminal status and configuration bank
`default_nettype none
package term_regs_pkg;

    typedef enum logic {
        bus_idle,
        bus_answer
    } bus_phase_t;

    typedef struct packed {
        logic       enh_bc;
        logic       enh_cpu;
        logic       stack_inc_eom;
        logic       gcb_enable;
        logic [2:0] gcb_size;
        logic       isq_no_invalid;
        logic       isq_no_valid;
        logic       isq_enable;
        logic       rt_addr_source;
        logic       enh_monitor;
        logic       resv;
        logic       reg_space_64;
        logic [1:0] clock_select;
    } cfg6_t;

    typedef struct packed {
        logic [5:0] mm_base;
        logic [4:0] resv;
        logic       rt_halt_en;
        logic       resp_1553b;
        logic       timetag_sync;
        logic       wdog_en;
        logic       mcr_in_command_indicator;
    } cfg7_t;

    typedef struct packed {
        logic [1:0] retry;
        logic       bad_msg;
        logic       status_set;
        logic       good_block;
        logic       format_err;
        logic       no_resp;
    } cond_in_t;

endpackage
`default_nettype wire

// [irq_unit.sv]
// sticky event status with read clear, mask and one level interrupt
`timescale 1ns/10ps
`default_nettype none
module irq_unit #(
    parameter int WIDTH = 4
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] events,
    input  wire logic             rd_clear,
    input  wire logic             mask_we,
    input  wire logic [WIDTH-1:0] mask_wdata,
    output logic      [WIDTH-1:0] status,
    output logic      [WIDTH-1:0] mask,
    output logic                  irq
);
    typedef struct packed {
        logic [WIDTH-1:0] status;
        logic [WIDTH-1:0] mask;
        logic             irq;
    } irq_state_t;

    irq_state_t st_reg;
    irq_state_t st_next;

    if (WIDTH < 1 || WIDTH > 16) begin : g_check
        $error("irq_unit width must be 1 to 16");
    end

    always_comb begin
        st_next = st_reg;
        // an event in the clearing cycle survives the clear
        st_next.status = (rd_clear ? '0 : st_reg.status) | events;
        if (mask_we) begin
            st_next.mask = mask_wdata;
        end
        st_next.irq = |(st_next.status & st_next.mask);
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign status = st_reg.status;
    assign mask   = st_reg.mask;
    assign irq    = st_reg.irq;
endmodule // irq_unit
`default_nettype wire

// [term_regs.sv]
// terminal status and configuration register bank behind an APB slave
`timescale 1ns/10ps
`default_nettype none
`include "term_regs_map.svh"
module term_regs #(
    parameter int ADDR_WIDTH = 8
) (
    input  wire logic                        mclk,
    input  wire logic                        reset,
    input  wire logic                        ce,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ADDR_WIDTH-1:0]       paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        bc_executing,
    input  wire term_regs_pkg::cond_in_t     cond_in,
    input  wire logic                        cmp_update,
    input  wire logic                        cmp_equal,
    input  wire logic                        cmp_less,
    input  wire logic [15:0]                 selftest_word,
    output term_regs_pkg::cfg6_t             cfg6,
    output term_regs_pkg::cfg7_t             cfg7,
    output logic      [7:0]                  gp_flags,
    output logic                             bc_online,
    output logic                             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        term_regs_pkg::bus_phase_t phase;
        logic                      pready;
        logic                      pslverr;
        logic [31:0]               prdata;
        term_regs_pkg::cfg6_t      cfg6;
        term_regs_pkg::cfg7_t      cfg7;
        logic [7:0]                gpf;
        logic                      online;
        logic [15:0]               prev_selftest;
        logic                      prev_bad;
        logic                      prev_noresp;
        logic                      prev_good;
    } regs_state_t;

    regs_state_t st_reg;
    regs_state_t st_next;

    if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_check
        $error("term_regs address width must be 8 to 32");
    end

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // word index of a byte address; misaligned addresses decode as unmapped
    function automatic logic [5:0] word_index(input logic [ADDR_WIDTH-1:0] a);
        word_index = a[7:2];
    endfunction

    function automatic logic mapped(input logic [ADDR_WIDTH-1:0] a);
        logic [5:0] idx;
        logic       hit;
        idx = word_index(a);
        hit = (idx == `IDX_SELFTEST) || (idx == `IDX_CFG6) ||
              (idx == `IDX_CFG7) || (idx == `IDX_FLAG_PORT) ||
              (idx == `IDX_IRQ_STATUS) || (idx == `IDX_IRQ_MASK);
        mapped = hit && (a[1:0] == 2'b00) && ((a >> 8) == '0);
    endfunction

    // reserved bits keep their reset value, so they always read zero
    function automatic logic [15:0] merge(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [15:0] wmask);
        merge = (old_v & ~wmask) | (new_v & wmask);
    endfunction

    function automatic logic [31:0] widen(input logic [15:0] v);
        widen = {16'h0000, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // condition word

    logic        online_now;
    logic [15:0] cond_word;

    always_comb begin
        online_now = st_reg.cfg6.enh_bc & bc_executing;
        cond_word  = `COND_ZERO;
        if (online_now) begin
            cond_word[`COND_ONE_BIT] = 1'b1;
            cond_word[14:8] = {cond_in.retry, cond_in.bad_msg,
                               cond_in.status_set, cond_in.good_block,
                               cond_in.format_err, cond_in.no_resp};
            cond_word[`COND_GPF_HI:`COND_GPF_LO] =
                st_reg.gpf[`COND_GPF_HI:`COND_GPF_LO];
            // the compare flags live in the low general flags
            cond_word[1:0] = st_reg.gpf[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt events

    logic [`IRQ_EVENTS-1:0] events;
    logic [`IRQ_EVENTS-1:0] irq_status;
    logic [`IRQ_EVENTS-1:0] irq_mask;
    logic                   irq_rd_clear;
    logic                   irq_mask_we;

    always_comb begin
        events                 = '0;
        // a new error bit in the self-test word, not one that stays up
        events[`EV_SELFTEST]   = |(selftest_word & ~st_reg.prev_selftest);
        events[`EV_BAD_MSG]    = cond_in.bad_msg & ~st_reg.prev_bad;
        events[`EV_NO_RESP]    = cond_in.no_resp & ~st_reg.prev_noresp;
        events[`EV_GOOD_BLOCK] = cond_in.good_block & ~st_reg.prev_good;
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus access

    logic       access;
    logic       finish;
    logic [5:0] acc_idx;

    always_comb begin
        access       = psel & penable;
        acc_idx      = word_index(paddr);
        // writes land on the edge the master completes
        finish       = access & st_reg.pready;
        // status clears on the edge that captures it: an event in the access
        // cycle then survives the clear instead of being lost unread
        irq_rd_clear = access & ~st_reg.pready & ~pwrite & mapped(paddr) &
                       (acc_idx == `IDX_IRQ_STATUS);
        irq_mask_we  = finish & pwrite & ~st_reg.pslverr &
                       (acc_idx == `IDX_IRQ_MASK);
    end

    always_comb begin
        st_next = st_reg;

        st_next.online        = online_now;
        st_next.prev_selftest = selftest_word;
        st_next.prev_bad      = cond_in.bad_msg;
        st_next.prev_noresp   = cond_in.no_resp;
        st_next.prev_good     = cond_in.good_block;

        case (st_reg.phase)
            term_regs_pkg::bus_idle: begin
                if (access) begin
                    st_next.phase   = term_regs_pkg::bus_answer;
                    st_next.pready  = 1'b1;
                    st_next.pslverr = ~mapped(paddr);
                    st_next.prdata  = 32'h0000_0000;
                    if (!pwrite && mapped(paddr)) begin
                        case (acc_idx)
                            `IDX_SELFTEST: begin
                                // transfer error bits 3..1 arrive in place
                                st_next.prdata = widen(selftest_word);
                            end
                            `IDX_CFG6: begin
                                st_next.prdata = widen(st_reg.cfg6);
                            end
                            `IDX_CFG7: begin
                                st_next.prdata = widen(st_reg.cfg7);
                            end
                            `IDX_FLAG_PORT: begin
                                // the flags come back only in the low byte of the condition word, and only while online
                                st_next.prdata = widen(cond_word);
                            end
                            `IDX_IRQ_STATUS: begin
                                st_next.prdata = widen({12'h000, irq_status});
                            end
                            `IDX_IRQ_MASK: begin
                                st_next.prdata = widen({12'h000, irq_mask});
                            end
                            default: begin
                                st_next.prdata = 32'h0000_0000;
                            end
                        endcase
                    end
                end
            end
            term_regs_pkg::bus_answer: begin
                if (finish) begin
                    st_next.phase   = term_regs_pkg::bus_idle;
                    st_next.pready  = 1'b0;
                    st_next.pslverr = 1'b0;
                    if (pwrite && !st_reg.pslverr) begin
                        case (acc_idx)
                            `IDX_CFG6: begin
                                st_next.cfg6 = merge(st_reg.cfg6, pwdata[15:0],
                                                     `CFG6_WMASK);
                            end
                            `IDX_CFG7: begin
                                st_next.cfg7 = merge(st_reg.cfg7, pwdata[15:0],
                                                     `CFG7_WMASK);
                            end
                            `IDX_FLAG_PORT: begin
                                // zeros leave a flag alone; set wins a same-write clash
                                st_next.gpf = (st_reg.gpf &
                                    ~pwdata[`FLAG_CLR_HI:`FLAG_CLR_LO]) |
                                    pwdata[`FLAG_SET_HI:`FLAG_SET_LO];
                            end
                            default: begin
                                st_next.gpf = st_reg.gpf;
                            end
                        endcase
                    end
                end else if (!access) begin
                    // master walked away; drop the answer rather than hang
                    st_next.phase   = term_regs_pkg::bus_idle;
                    st_next.pready  = 1'b0;
                    st_next.pslverr = 1'b0;
                end
            end
            default: begin
                st_next.phase  = term_regs_pkg::bus_idle;
                st_next.pready = 1'b0;
            end
        endcase

        // the controller's own compare result beats a host write in the same cycle
        if (cmp_update) begin
            st_next.gpf[1] = cmp_equal;
            st_next.gpf[0] = cmp_less;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_reg               <= '0;
            st_reg.phase         <= term_regs_pkg::bus_idle;
            st_reg.cfg6          <= `CFG6_RST;
            st_reg.cfg7          <= `CFG7_RST;
            st_reg.gpf           <= `GPF_RST;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    irq_unit #(
        .WIDTH      (`IRQ_EVENTS)
    ) u_irq (
        .mclk       (mclk),
        .reset      (reset),
        .ce         (ce),
        .events     (events),
        .rd_clear   (irq_rd_clear),
        .mask_we    (irq_mask_we),
        .mask_wdata (pwdata[`IRQ_EVENTS-1:0]),
        .status     (irq_status),
        .mask       (irq_mask),
        .irq        (irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata    = st_reg.prdata;
    assign pready    = st_reg.pready;
    assign pslverr   = st_reg.pslverr;
    assign cfg6      = st_reg.cfg6;
    assign cfg7      = st_reg.cfg7;
    assign gp_flags  = st_reg.gpf;
    assign bc_online = st_reg.online;

endmodule // term_regs
`default_nettype wire

// [term_regs_chk.sv]
// concurrent checks on the ports of the terminal register bank
`timescale 1ns/10ps
`default_nettype none
`include "term_regs_map.svh"
module term_regs_chk #(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic                    mclk,
    input wire logic                    reset,
    input wire logic                    ce,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [ADDR_WIDTH-1:0]   paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic                    bc_executing,
    input wire term_regs_pkg::cond_in_t cond_in,
    input wire logic                    cmp_update,
    input wire logic                    cmp_equal,
    input wire logic                    cmp_less,
    input wire logic [15:0]             selftest_word,
    input wire term_regs_pkg::cfg6_t    cfg6,
    input wire term_regs_pkg::cfg7_t    cfg7,
    input wire logic [7:0]              gp_flags,
    input wire logic                    bc_online,
    input wire logic                    irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////
    sequence take_s; psel && penable && !pready && ce; endsequence
    sequence done_s; psel && penable && pready && !pslverr && ce; endsequence
    sequence wr_s(a); done_s ##0 (pwrite && paddr == a); endsequence
    sequence rd_s(a); done_s ##0 (!pwrite && paddr == a); endsequence
    ////////////////////////////////////////////////////////////
    answer_next_a: assert property (take_s |=> pready) else $error("no answer after request");
    pready_one_a: assert property (pready && ce |=> !pready) else $error("ready held too long");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper read half set");
    flag_update_a:
        assert property (wr_s(8'h6C) |=> gp_flags[7:2] ==
            (($past(gp_flags[7:2]) & ~$past(pwdata[15:10])) | $past(pwdata[7:2])))
        else $error("flag port write gave wrong flags");
    offline_zero_a:
        assert property (rd_s(8'h6C) ##0 (!bc_online && !$past(bc_online)) |-> prdata[15:0] == 16'h0000)
        else $error("condition word not zero while offline");
    online_cond_a:
        assert property (rd_s(8'h6C) ##0 (bc_online && $past(bc_online)) |->
            prdata[15] && prdata[14:8] == $past(cond_in) && prdata[7:2] == gp_flags[7:2])
        else $error("condition word layout wrong");
    selftest_rd_a:
        assert property (rd_s(8'h3C) |-> prdata[15:0] == $past(selftest_word))
        else $error("selftest word read wrong");
    cfg6_write_a:
        assert property (wr_s(8'h60) |=> cfg6 == ($past(pwdata[15:0]) & `CFG6_WMASK))
        else $error("config six write wrong");
    cfg7_write_a:
        assert property (wr_s(8'h64) |=> cfg7 == ($past(pwdata[15:0]) & `CFG7_WMASK))
        else $error("config seven write wrong");
endmodule // term_regs_chk

bind term_regs term_regs_chk #(.ADDR_WIDTH(ADDR_WIDTH)) chk (
    .mclk(mclk), .reset(reset), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bc_executing(bc_executing), .cond_in(cond_in), .cmp_update(cmp_update),
    .cmp_equal(cmp_equal), .cmp_less(cmp_less), .selftest_word(selftest_word),
    .cfg6(cfg6), .cfg7(cfg7), .gp_flags(gp_flags), .bc_online(bc_online), .irq(irq)
);
`default_nettype wire

// [term_regs_bench.sv]
// self-checking bench for the terminal register bank
`timescale 1ns/10ps
`default_nettype none
module term_regs_bench;
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [15:0] data;
        logic [15:0] exp;
        logic        err;
    } row_t;
    logic                    mclk = 1'b0;
    logic                    reset = 1'b1;
    logic                    ce = 1'b1;
    logic                    psel = 1'b0;
    logic                    penable = 1'b0;
    logic                    pwrite = 1'b0;
    logic [7:0]              paddr = 8'h00;
    logic [31:0]             pwdata = 32'h0;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    bc_executing = 1'b1;
    term_regs_pkg::cond_in_t cond_in = 7'h52;
    logic                    cmp_update = 1'b0;
    logic                    cmp_equal = 1'b0;
    logic                    cmp_less = 1'b0;
    logic [15:0]             selftest_word = 16'hC00E;
    term_regs_pkg::cfg6_t    cfg6;
    term_regs_pkg::cfg7_t    cfg7;
    logic [7:0]              gp_flags;
    logic                    bc_online;
    logic                    irq;
    logic [31:0]             rd;
    logic                    er;
    int                      num_errors = 0;
    int                      cmp_count = 0;
    // rows depend on the ones before: cfg6 all ones keeps the controller online
    row_t rows [18] = '{
        '{0, 8'h60, 16'h0, 16'h0000, 0}, '{0, 8'h84, 16'h0, 16'h0000, 0},
        '{1, 8'h60, 16'hFFFF, 16'h0, 0}, '{0, 8'h60, 16'h0, 16'hFFF7, 0},
        '{1, 8'h64, 16'hFFFF, 16'h0, 0}, '{0, 8'h64, 16'h0, 16'hFC1F, 0},
        '{0, 8'h3C, 16'h0, 16'hC00E, 0}, '{1, 8'h3C, 16'h1234, 16'h0, 0},
        '{0, 8'h3C, 16'h0, 16'hC00E, 0}, '{0, 8'h10, 16'h0, 16'h0000, 1},
        '{1, 8'h6C, 16'h00FC, 16'h0, 0}, '{0, 8'h6C, 16'h0, 16'hD2FC, 0},
        '{1, 8'h6C, 16'h3003, 16'h0, 0}, '{0, 8'h6C, 16'h0, 16'hD2CF, 0},
        '{1, 8'h6C, 16'h0101, 16'h0, 0}, '{0, 8'h6C, 16'h0, 16'hD2CF, 0},
        '{0, 8'h6D, 16'h0, 16'h0000, 1}, '{1, 8'h10, 16'h5555, 16'h0, 1}
    };

    term_regs dut (
        .mclk(mclk), .reset(reset), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bc_executing(bc_executing), .cond_in(cond_in), .cmp_update(cmp_update),
        .cmp_equal(cmp_equal), .cmp_less(cmp_less), .selftest_word(selftest_word),
        .cfg6(cfg6), .cfg7(cfg7), .gp_flags(gp_flags), .bc_online(bc_online), .irq(irq)
    );

    always #10 mclk = ~mclk;
    ////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // starts on a fresh edge so psel is never assigned twice in one step
    task apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            if (n > 20) begin
                num_errors++;
                report_and_stop();
            end
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd_chk(input logic [7:0] a, input logic [15:0] exp);
        apb(1'b0, a, 16'h0);
        chk(rd, {16'h0000, exp});
    endtask

    task wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1) begin
            n++;
            if (n > 8) begin
                num_errors++;
                report_and_stop();
            end
            @(posedge mclk);
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        chk({cfg6, cfg7}, 32'h0);
        chk({22'h0, gp_flags, irq, bc_online}, 32'h0);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].data);
            chk({31'h0, er}, {31'h0, rows[i].err});
            if (!rows[i].wr) chk(rd, {16'h0000, rows[i].exp});
        end
        $display("test table done");
        @(posedge mclk);
        cmp_less <= 1'b1;
        cmp_update <= 1'b1;
        @(posedge mclk);
        cmp_update <= 1'b0;
        @(posedge mclk);
        chk({24'h0, gp_flags}, 32'hCD);
        rd_chk(8'h6C, 16'hD2CD);
        chk({31'h0, bc_online}, 32'h1);
        $display("test compare done");
        apb(1'b0, 8'h80, 16'h0);
        apb(1'b1, 8'h84, 16'h0002);
        cond_in.bad_msg <= 1'b0;
        repeat (3) @(posedge mclk);
        cond_in.bad_msg <= 1'b1;
        wait_irq();
        rd_chk(8'h80, 16'h0002);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 8'h84, 16'h0000);
        cond_in.no_resp <= 1'b1;
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        rd_chk(8'h80, 16'h0004);
        rd_chk(8'h84, 16'h0000);
        cond_in.no_resp <= 1'b0;
        $display("test irq done");
        bc_executing <= 1'b0;
        repeat (3) @(posedge mclk);
        chk({31'h0, bc_online}, 32'h0);
        rd_chk(8'h6C, 16'h0000);
        bc_executing <= 1'b1;
        apb(1'b1, 8'h60, 16'h3AC0);
        repeat (3) @(posedge mclk);
        rd_chk(8'h6C, 16'h0000);
        chk({24'h0, cfg6.stack_inc_eom, cfg6.gcb_enable, cfg6.gcb_size, cfg6.isq_no_invalid,
             cfg6.isq_no_valid, cfg6.isq_enable}, 32'hEB);
        $display("test offline done");
        apb(1'b1, 8'h64, 16'hA816);
        @(posedge mclk);
        chk({18'h0, cfg7.mm_base, cfg7.resv, cfg7.rt_halt_en, cfg7.timetag_sync,
             cfg7.wdog_en}, 32'h2A07);
        $display("test cfg7 done");
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        chk({cfg6, cfg7}, 32'h0);
        chk({24'h0, gp_flags}, 32'h0);
        rd_chk(8'h6C, 16'h0000);
        $display("test reset done");
        report_and_stop();
    end
endmodule // term_regs_bench
`default_nettype wire
